/* File: src/hicr_regs.sv */
// Hub identity and configuration register bank: identifiers and power select.
// Assumes the SMBus slave or EEPROM loader drives the byte-wide config port
// synchronously to clk_i, and that the select pins are stable at reset release.
`timescale 1ns/100ps

module hicr_regs #(
  parameter logic [7:0] DEF_VENDOR_ID_LOW       = 8'hA5, // Arbitrary value
  parameter logic [7:0] DEF_VENDOR_ID_HIGH      = 8'h5A, // Arbitrary value
  parameter logic [7:0] DEF_PRODUCT_ID_LOW      = 8'h01, // Arbitrary value
  parameter logic [7:0] DEF_PRODUCT_ID_HIGH     = 8'h10, // Arbitrary value
  parameter logic [7:0] DEF_RELEASE_NUMBER_LOW  = 8'h00, // Arbitrary value
  parameter logic [7:0] DEF_RELEASE_NUMBER_HIGH = 8'h01, // Arbitrary value
  parameter logic [7:0] DEF_HUB_CONFIG_FIRST    = 8'h80  // Self-powered default byte
)(
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  input  wire logic [1:0]  cfg_select_i,
  input  wire logic        cfg_wr_i,
  input  wire logic        cfg_rd_i,
  input  wire logic [7:0]  cfg_addr_i,
  input  wire logic [7:0]  cfg_wdata_i,
  input  wire logic        dyn_pwr_en_i,
  input  wire logic        local_power_input_i,
  output logic      [7:0]  cfg_rdata_o,
  output logic             cfg_rvalid_o,
  output logic      [2:0]  config_mode_o,
  output logic             strap_enable_o,
  output logic      [15:0] vendor_id_o,
  output logic      [15:0] product_id_o,
  output logic      [15:0] release_number_o,
  output logic             self_powered_o
);

  // Offset decode shared by read and write paths
  function automatic logic [hicr_pkg::IDX_W:0] decode_ofs(input logic [7:0] ofs);
    decode_ofs = '0;
    if (ofs < 8'(hicr_pkg::NUM_REGS))
    begin
      decode_ofs = {1'b1, ofs[hicr_pkg::IDX_W-1:0]};
    end
  endfunction : decode_ofs

  hicr_pkg::hicr_mode_t            mode;
  hicr_pkg::hicr_mode_t            next_mode;
  logic [7:0]                      regs [hicr_pkg::NUM_REGS];
  logic [7:0]                      next_regs [hicr_pkg::NUM_REGS];
  logic [7:0]                      next_cfg_rdata;
  logic                            next_cfg_rvalid;
  logic                            next_strap_enable;
  logic [15:0]                     next_vendor_id;
  logic [15:0]                     next_product_id;
  logic [15:0]                     next_release_number;
  logic                            next_self_powered;
  logic [hicr_pkg::IDX_W:0]        wr_dec;
  logic [hicr_pkg::IDX_W:0]        rd_dec;
  logic                            ext_mode;

  // Index width must reach every register of the bank
  if ((1 << hicr_pkg::IDX_W) < hicr_pkg::NUM_REGS)
  begin : g_idx_check
    $error("register index too narrow for the bank");
  end

  // Mode capture and register file next values
  always_comb
  begin
    next_mode = mode;
    next_regs = regs;
    ext_mode  = (mode == hicr_pkg::MODE_SMBUS) || (mode == hicr_pkg::MODE_EEPROM);
    wr_dec    = decode_ofs(cfg_addr_i);
    rd_dec    = decode_ofs(cfg_addr_i);
    case (mode)
      hicr_pkg::MODE_WAIT:
      begin
        // First edge after release catches the select pins
        case (cfg_select_i)
          hicr_pkg::SEL_SMBUS:       next_mode = hicr_pkg::MODE_SMBUS;
          hicr_pkg::SEL_EEPROM:      next_mode = hicr_pkg::MODE_EEPROM;
          hicr_pkg::SEL_DEFAULT_BUS: next_mode = hicr_pkg::MODE_DEFAULT_BUS;
          default:                   next_mode = hicr_pkg::MODE_DEFAULT;
        endcase
        if (cfg_select_i == hicr_pkg::SEL_DEFAULT || cfg_select_i == hicr_pkg::SEL_DEFAULT_BUS)
        begin
          next_regs[0] = DEF_VENDOR_ID_LOW;
          next_regs[1] = DEF_VENDOR_ID_HIGH;
          next_regs[2] = DEF_PRODUCT_ID_LOW;
          next_regs[3] = DEF_PRODUCT_ID_HIGH;
          next_regs[4] = DEF_RELEASE_NUMBER_LOW;
          next_regs[5] = DEF_RELEASE_NUMBER_HIGH;
          next_regs[6] = DEF_HUB_CONFIG_FIRST;
          next_regs[6][hicr_pkg::POWER_SOURCE_SELECT_BIT] = (cfg_select_i == hicr_pkg::SEL_DEFAULT);
        end
      end
      hicr_pkg::MODE_SMBUS, hicr_pkg::MODE_EEPROM:
      begin
        // External source loads bytes; zero until then
        if (cfg_wr_i && wr_dec[hicr_pkg::IDX_W])
        begin
          next_regs[wr_dec[hicr_pkg::IDX_W-1:0]] = cfg_wdata_i;
        end
      end
      hicr_pkg::MODE_DEFAULT, hicr_pkg::MODE_DEFAULT_BUS:
      begin
        next_mode = mode;
      end
      default:
      begin
        next_mode = hicr_pkg::MODE_WAIT;
      end
    endcase
  end

  // Mode and register file storage
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      mode <= hicr_pkg::MODE_WAIT;
      for (int i = 0; i < hicr_pkg::NUM_REGS; i++)
      begin
        regs[i] <= hicr_pkg::REG_RESET;
      end
    end
    else
    begin
      mode <= next_mode;
      regs <= next_regs;
    end
  end

  // Read answer and upstream presentation next values
  always_comb
  begin
    next_cfg_rvalid = cfg_rd_i && ext_mode;
    next_cfg_rdata  = hicr_pkg::UNMAPPED_READ;
    if (cfg_rd_i && ext_mode && rd_dec[hicr_pkg::IDX_W])
    begin
      next_cfg_rdata = regs[rd_dec[hicr_pkg::IDX_W-1:0]];
    end
    next_strap_enable   = (mode == hicr_pkg::MODE_DEFAULT) || (mode == hicr_pkg::MODE_DEFAULT_BUS);
    next_vendor_id      = {regs[1], regs[0]};
    next_product_id     = {regs[3], regs[2]};
    next_release_number = {regs[5], regs[4]};
    if (dyn_pwr_en_i)
    begin
      next_self_powered = local_power_input_i;
    end
    else
    begin
      next_self_powered = regs[6][hicr_pkg::POWER_SOURCE_SELECT_BIT];
    end
  end

  // Output registers
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      cfg_rdata_o      <= hicr_pkg::UNMAPPED_READ;
      cfg_rvalid_o     <= 1'b0;
      config_mode_o    <= 3'h0;
      strap_enable_o   <= 1'b0;
      vendor_id_o      <= 16'h0000;
      product_id_o     <= 16'h0000;
      release_number_o <= 16'h0000;
      self_powered_o   <= 1'b0;
    end
    else
    begin
      cfg_rdata_o      <= next_cfg_rdata;
      cfg_rvalid_o     <= next_cfg_rvalid;
      config_mode_o    <= 3'(mode);
      strap_enable_o   <= next_strap_enable;
      vendor_id_o      <= next_vendor_id;
      product_id_o     <= next_product_id;
      release_number_o <= next_release_number;
      self_powered_o   <= next_self_powered;
    end
  end

  // Checks
  sequence s_ext_write(logic [7:0] ofs);
    mode == hicr_pkg::MODE_EEPROM && cfg_wr_i && cfg_addr_i == ofs;
  endsequence

  a_vendor_low_write: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    s_ext_write(8'h00) |=> ##1 vendor_id_o[7:0] == $past(cfg_wdata_i, 2))
    else $error("vendor low byte not presented");
  a_vendor_high_write: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    s_ext_write(8'h01) |=> ##1 vendor_id_o[15:8] == $past(cfg_wdata_i, 2))
    else $error("vendor high byte not presented");
  a_product_low_write: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    s_ext_write(8'h02) |=> ##1 product_id_o[7:0] == $past(cfg_wdata_i, 2))
    else $error("product low byte not presented");
  a_product_high_write: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    s_ext_write(8'h03) |=> ##1 product_id_o[15:8] == $past(cfg_wdata_i, 2))
    else $error("product high byte not presented");
  a_release_low_write: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    s_ext_write(8'h04) |=> ##1 release_number_o[7:0] == $past(cfg_wdata_i, 2))
    else $error("release low byte not presented");
  a_release_high_write: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    s_ext_write(8'h05) |=> ##1 release_number_o[15:8] == $past(cfg_wdata_i, 2))
    else $error("release high byte not presented");
  a_power_bit_write: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    s_ext_write(8'h06) ##1 !dyn_pwr_en_i |=> self_powered_o == $past(cfg_wdata_i[7], 2))
    else $error("power select bit not applied");
  a_read_back: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    s_ext_write(8'h03) ##1 cfg_rd_i && cfg_addr_i == 8'h03
    |=> cfg_rvalid_o && cfg_rdata_o == $past(cfg_wdata_i, 2))
    else $error("read back differs from write");
  a_mode_capture: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    mode == hicr_pkg::MODE_WAIT && cfg_select_i == hicr_pkg::SEL_EEPROM
    |=> mode == hicr_pkg::MODE_EEPROM && regs[0] == hicr_pkg::REG_RESET ##1 !strap_enable_o)
    else $error("eeprom mode not captured");
  a_local_power: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    dyn_pwr_en_i |=> self_powered_o == $past(local_power_input_i))
    else $error("local power input not used");

endmodule : hicr_regs

/* File: src/hicr_pkg.sv */
// Shared constants for the hub identity and configuration register bank.
// Assumes a single clock domain; offsets are byte addresses on the config port.
package hicr_pkg;

  // Register offsets on the configuration port
  localparam logic [7:0] OFS_VENDOR_ID_LOW       = 8'h00;
  localparam logic [7:0] OFS_VENDOR_ID_HIGH      = 8'h01;
  localparam logic [7:0] OFS_PRODUCT_ID_LOW      = 8'h02;
  localparam logic [7:0] OFS_PRODUCT_ID_HIGH     = 8'h03;
  localparam logic [7:0] OFS_RELEASE_NUMBER_LOW  = 8'h04;
  localparam logic [7:0] OFS_RELEASE_NUMBER_HIGH = 8'h05;
  localparam logic [7:0] OFS_HUB_CONFIG_FIRST    = 8'h06;

  // Number of registers in the bank and index width
  localparam int unsigned NUM_REGS  = 7;
  localparam int unsigned IDX_W     = 3;

  // Field position of the power source select bit in the first config byte
  localparam int unsigned POWER_SOURCE_SELECT_BIT = 7;

  // Reset value of every register before it is loaded
  localparam logic [7:0] REG_RESET = 8'h00;
  // Read answer for an unmapped offset
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // Configuration select pin codes
  localparam logic [1:0] SEL_DEFAULT      = 2'h0;
  localparam logic [1:0] SEL_SMBUS        = 2'h1;
  localparam logic [1:0] SEL_DEFAULT_BUS  = 2'h2;
  localparam logic [1:0] SEL_EEPROM       = 2'h3;

  // Configuration modes: wait from reset, then the one chosen after reset release
  typedef enum logic [2:0]
  {
    MODE_WAIT,
    MODE_DEFAULT,
    MODE_DEFAULT_BUS,
    MODE_SMBUS,
    MODE_EEPROM
  } hicr_mode_t;

endpackage : hicr_pkg

/* File: dv/hicr_host.sv */
// Loader model driving the byte-wide config port.
// Assumes one caller; strobes are one-cycle pulses.
`timescale 1ns/100ps
module hicr_host (
  input  wire logic       clk_i,
  input  wire logic [7:0] rdata_i,
  input  wire logic       rvalid_i,
  output logic            wr_o,
  output logic            rd_o,
  output logic      [7:0] addr_o,
  output logic      [7:0] wdata_o
);
  // Quiet port at time zero
  initial
  begin
    wr_o = 1'b0;
    rd_o = 1'b0;
    addr_o = 8'h00;
    wdata_o = 8'h00;
  end
  // One write or read, answer taken after the accepting edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                      output logic v, output logic [7:0] q);
    @(posedge clk_i);
    #1;
    wr_o = w;
    rd_o = !w;
    addr_o = a;
    wdata_o = d;
    @(posedge clk_i);
    #1;
    v = rvalid_i;
    q = rdata_i;
    wr_o = 1'b0;
    rd_o = 1'b0;
    addr_o = ~a; // Released lines show inverse
    wdata_o = ~d;
  endtask : xfer
  // Write then read the same offset on back-to-back edges
  task automatic write_read(input logic [7:0] a, input logic [7:0] d,
                            output logic v, output logic [7:0] q);
    @(posedge clk_i);
    #1;
    wr_o = 1'b1;
    addr_o = a;
    wdata_o = d;
    @(posedge clk_i);
    #1;
    wr_o = 1'b0;
    rd_o = 1'b1;
    wdata_o = ~d;
    @(posedge clk_i);
    #1;
    v = rvalid_i;
    q = rdata_i;
    rd_o = 1'b0;
    addr_o = ~a;
  endtask : write_read
endmodule : hicr_host

/* File: dv/tb.sv */
// Self-checking bench for the identity register bank.
// Assumes hicr_host drives the config port.
`timescale 1ns/100ps
module tb;
  logic        clk_i;
  logic        rst_b_i;
  logic [1:0]  sel;
  logic        dyn;
  logic        loc;
  logic        wr;
  logic        rd;
  logic [7:0]  addr;
  logic [7:0]  wdata;
  logic [7:0]  rdata;
  logic        rvalid;
  logic [2:0]  mode;
  logic        strap;
  logic [15:0] vid;
  logic [15:0] pid;
  logic [15:0] rel;
  logic        selfp;
  logic        v;
  logic [7:0]  q;
  logic [7:0]  regs [7];
  int          error_cnt;
  int          checks_done;

  hicr_regs i_dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .cfg_select_i(sel), .cfg_wr_i(wr), .cfg_rd_i(rd),
    .cfg_addr_i(addr), .cfg_wdata_i(wdata), .dyn_pwr_en_i(dyn), .local_power_input_i(loc),
    .cfg_rdata_o(rdata), .cfg_rvalid_o(rvalid), .config_mode_o(mode), .strap_enable_o(strap),
    .vendor_id_o(vid), .product_id_o(pid), .release_number_o(rel), .self_powered_o(selfp));
  hicr_host h (.clk_i(clk_i), .rdata_i(rdata), .rvalid_i(rvalid), .wr_o(wr), .rd_o(rd),
    .addr_o(addr), .wdata_o(wdata));

  // Free-running clock
  initial
  begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  // Shared mismatch bookkeeping
  task automatic note_result(input string n, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e)
    begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask : note_result
  // Compare the reported mode
  task automatic chk_mode(input logic [2:0] e, input logic [2:0] g);
    note_result("mode", 16'(e), 16'(g));
  endtask : chk_mode
  // Compare a one-bit status
  task automatic chk_flag(input string n, input logic e, input logic g);
    note_result(n, 16'(e), 16'(g));
  endtask : chk_flag
  // Compare a read answer, valid over data
  task automatic chk_read(input string n, input logic [8:0] e, input logic [8:0] g);
    note_result(n, 16'(e), 16'(g));
  endtask : chk_read
  // Compare a presented identifier
  task automatic chk_id(input string n, input logic [15:0] e, input logic [15:0] g);
    note_result(n, e, g);
  endtask : chk_id
  // Report and stop
  task automatic give_verdict();
    $display("errors %0d checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : give_verdict
  // Reset with given pins, then move the pins
  task automatic do_reset(input logic [1:0] s);
    rst_b_i = 1'b0;
    sel = s;
    repeat (5) @(posedge clk_i);
    #1;
    rst_b_i = 1'b1;
    repeat (3) @(posedge clk_i);
    #1;
    sel = ~s;
  endtask : do_reset
  // Mode expected for a pin code
  function automatic logic [2:0] exp_mode(input logic [1:0] s);
    case (s)
      hicr_pkg::SEL_SMBUS:   return hicr_pkg::MODE_SMBUS;
      hicr_pkg::SEL_EEPROM:  return hicr_pkg::MODE_EEPROM;
      hicr_pkg::SEL_DEFAULT: return hicr_pkg::MODE_DEFAULT;
      default:               return hicr_pkg::MODE_DEFAULT_BUS;
    endcase
  endfunction : exp_mode
  // Hang guard
  initial
  begin
    #300000;
    error_cnt++;
    give_verdict();
  end
  // Main sequence
  initial
  begin
    error_cnt = 0;
    checks_done = 0;
    dyn = 1'b0;
    loc = 1'b0;
    rst_b_i = 1'b0;
    sel = 2'h0;
    void'($urandom(90298));
    for (int s = 0; s < 4; s++)
    begin
      do_reset(2'(s));
      chk_mode(exp_mode(2'(s)), mode);
      chk_flag("strap", !s[0], strap);
      chk_flag("self", s == 0, selfp);
      h.xfer(1'b0, hicr_pkg::OFS_VENDOR_ID_LOW, 8'h00, v, q);
      chk_read("read", {s[0], 8'h00}, {v, q});
    end
    for (int r = 0; r < 4; r++)
    begin
      // Later rounds load through the SMBus path instead of the EEPROM path
      if (r == 2)
      begin
        do_reset(hicr_pkg::SEL_SMBUS);
        chk_mode(hicr_pkg::MODE_SMBUS, mode);
      end
      for (int a = 0; a < 7; a++)
      begin
        regs[a] = (r == 0) ? 8'hFF : (r == 2) ? 8'h7F : 8'($urandom);
        h.xfer(1'b1, 8'(a), regs[a], v, q);
      end
      for (int a = 0; a < 7; a++)
      begin
        h.xfer(1'b0, 8'(a), 8'h00, v, q);
        chk_read("read", {1'b1, regs[a]}, {v, q});
      end
      // Read right behind a write returns the new byte
      regs[3] = 8'($urandom);
      h.write_read(hicr_pkg::OFS_PRODUCT_ID_HIGH, regs[3], v, q);
      chk_read("read", {1'b1, regs[3]}, {v, q});
      for (int k = 0; k < 2; k++)
      begin
        h.xfer(1'b1, k ? 8'($urandom_range(255, 8)) : 8'h07, 8'($urandom), v, q);
        h.xfer(1'b0, k ? 8'($urandom_range(255, 8)) : 8'h07, 8'h00, v, q);
        chk_read("unmapped", {1'b1, hicr_pkg::UNMAPPED_READ}, {v, q});
      end
      chk_id("vendor", {regs[1], regs[0]}, vid);
      chk_id("product", {regs[3], regs[2]}, pid);
      chk_id("release", {regs[5], regs[4]}, rel);
      dyn = r[0];
      loc = r[1];
      repeat (2) @(posedge clk_i);
      #1;
      chk_flag("self", dyn ? loc : regs[6][hicr_pkg::POWER_SOURCE_SELECT_BIT], selfp);
    end
    give_verdict();
  end
endmodule : tb
